// *** src/fault_supervisor_pkg.sv ***
package fault_supervisor_pkg;

  // clock rate
  localparam int unsigned CLK_HZ = 50_000_000;

  // power-up diagnostic run time and refresh period
  localparam int unsigned DIAG_TIME_US    = 10;
  localparam int unsigned REFRESH_TIME_US = 100;
  localparam int unsigned DIAG_CYCLES     = (DIAG_TIME_US * (CLK_HZ / 1_000_000) < 1) ? 1 :
                                            DIAG_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned REFRESH_CYCLES  = REFRESH_TIME_US * (CLK_HZ / 1_000_000);
  localparam logic [15:0] DIAG_LAST       = 16'(DIAG_CYCLES - 1);

  // apb register byte offsets
  localparam logic [7:0] ADDR_STATUS  = 8'h00;
  localparam logic [7:0] ADDR_FATAL   = 8'h04;
  localparam logic [7:0] ADDR_NFATAL  = 8'h08;
  localparam logic [7:0] ADDR_SFLAG   = 8'h0c;
  localparam logic [7:0] ADDR_CONTROL = 8'h10;
  localparam logic [7:0] ADDR_IOCFG   = 8'h14;

  // special flag memory bit positions
  localparam int unsigned SF_RUNTIME = 0;
  localparam int unsigned SF_COMPILE = 1;
  localparam int unsigned SF_RTPROG  = 2;
  localparam int unsigned SF_CFGCHG  = 3;
  localparam int unsigned SF_WIDTH   = 4;

  // control register bit positions
  localparam int unsigned CTL_STOP = 0;

  // error widths, category codes, reset values
  localparam int unsigned CODE_W     = 8;
  localparam int unsigned CFG_W      = 8;
  localparam logic [1:0]  CAT_NONE    = 2'h0;
  localparam logic [1:0]  CAT_RUNTIME = 2'h1;
  localparam logic [1:0]  CAT_COMPILE = 2'h2;
  localparam logic [1:0]  CAT_RTPROG  = 2'h3;
  localparam logic [7:0]  CODE_RST    = 8'h00;
  localparam logic [7:0]  CFG_RST     = 8'h00;
  localparam logic [7:0]  CODE_PTR    = 8'h01;
  localparam logic [15:0] PTR_LIMIT   = 16'h0fff;

  // mode selector positions
  typedef enum logic [1:0] {
    SW_STOP = 2'b00,
    SW_RUN  = 2'b01,
    SW_TERM = 2'b10
  } mode_sw_t;

  // operating modes
  typedef enum logic [1:0] {
    MODE_DIAG  = 2'b00,
    MODE_RUN   = 2'b01,
    MODE_STOP  = 2'b10,
    MODE_FATAL = 2'b11
  } mode_t;

endpackage

// *** src/controller_fault_supervisor.sv ***
// What this block does
// RULE1 - errors are fatal or non-fatal; non-fatal split into three categories
// RULE2 - every generated error leaves a code readable by the programming station
// RULE3 - a fatal error halts user program execution
// RULE4 - after fatal error, block stays safe and still answers status reads
// RULE5 - fatal error enters stop, lights fault and stop lamps, outputs off
// RULE6 - fatal state holds until restart after the error is removed
// RULE7 - restart comes from power cycle or selector run/term to stop
// RULE8 - restart clears the fatal latch and runs power-up diagnostics
// RULE9 - diagnostics failing relights fault; passing resumes normal operation
// RULE10 - non-fatal errors do not stop execution or i/o updates
// RULE11 - non-fatal errors in run mode show in special flag bits
// RULE12 - at startup the i/o configuration is stored and flagged
// RULE13 - i/o module status in special flags is refreshed periodically
// RULE14 - config mismatch sets changed flag and freezes module update
// RULE15 - changed flag clears only when i/o matches stored configuration
// RULE16 - download is checked; a rule violation aborts it with a code
// RULE17 - an aborted download leaves the stored program intact
// RULE18 - out-of-range pointer during execution flags run-time programming error
// RULE19 - non-fatal error keeps mode, logs flag, execution continues
// RULE20 - user program may request a change to stop mode
// RULE21 - last fatal and non-fatal codes readable; fatal cleared on restart
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/100ps
`default_nettype none

module controller_fault_supervisor
  import fault_supervisor_pkg::*;
#(
  parameter int unsigned REFRESH_LEN = fault_supervisor_pkg::REFRESH_CYCLES
) (
  // clock and reset
  input  wire logic                                 i_clk,
  input  wire logic                                 i_rst,
  // apb slave
  input  wire logic                                 i_psel,
  input  wire logic                                 i_penable,
  input  wire logic                                 i_pwrite,
  input  wire logic [7:0]                           i_paddr,
  input  wire logic [31:0]                          i_pwdata,
  output logic [31:0]                               o_prdata,
  output logic                                      o_pready,
  output logic                                      o_pslverr,
  // mode selector and diagnostics
  input  wire logic [1:0]                           i_mode_sw,
  input  wire logic                                 i_diag_fail,
  // error sources
  input  wire logic                                 i_fatal_err,
  input  wire logic [fault_supervisor_pkg::CODE_W-1:0] i_fatal_code,
  input  wire logic                                 i_rt_err,
  input  wire logic [fault_supervisor_pkg::CODE_W-1:0] i_rt_code,
  input  wire logic                                 i_ptr_valid,
  input  wire logic [15:0]                          i_ptr_addr,
  input  wire logic                                 i_user_stop,
  // program download
  input  wire logic                                 i_dl_start,
  input  wire logic                                 i_dl_viol,
  input  wire logic [fault_supervisor_pkg::CODE_W-1:0] i_dl_viol_code,
  input  wire logic                                 i_dl_end,
  // i/o configuration
  input  wire logic [fault_supervisor_pkg::CFG_W-1:0]  i_io_cfg,
  // status outputs
  output logic                                      o_prog_run,
  output logic                                      o_stop_led,
  output logic                                      o_fault_led,
  output logic                                      o_outputs_off,
  output logic                                      o_io_update_en,
  output logic                                      o_prog_commit,
  output logic [fault_supervisor_pkg::SF_WIDTH-1:0] o_sf_flags,
  output logic [fault_supervisor_pkg::CFG_W-1:0]    o_sf_io_status
);
  import fault_supervisor_pkg::*;

  // state
  mode_t                mode_q, mode_d;
  logic [15:0]          diag_cnt_q;
  logic [1:0]           sw_q;
  logic                 stop_hold_q;
  logic [CODE_W-1:0]    fatal_code_q;
  logic [CODE_W-1:0]    nf_code_q;
  logic [1:0]           nf_cat_q;
  logic [SF_WIDTH-1:0]  sf_q;
  logic [CFG_W-1:0]     cfg_store_q;
  logic [CFG_W-1:0]     io_stat_q;
  logic [31:0]          refresh_cnt_q;
  logic                 dl_active_q;
  logic                 commit_q;
  logic                 ctl_stop_q;
  logic [31:0]          rdata_q;

  // apb decode
  wire apb_setup  = i_psel & ~i_penable;
  wire apb_access = i_psel & i_penable;
  wire hit_status = (i_paddr == ADDR_STATUS);
  wire hit_fatal  = (i_paddr == ADDR_FATAL);
  wire hit_nfatal = (i_paddr == ADDR_NFATAL);
  wire hit_sflag  = (i_paddr == ADDR_SFLAG);
  wire hit_ctl    = (i_paddr == ADDR_CONTROL);
  wire hit_iocfg  = (i_paddr == ADDR_IOCFG);
  wire hit_any    = hit_status | hit_fatal | hit_nfatal |
                    hit_sflag | hit_ctl | hit_iocfg;
  wire wr_sflag   = apb_access & i_pwrite & hit_sflag;
  wire wr_ctl     = apb_access & i_pwrite & hit_ctl;

  // mode selector events
  wire sw_was_on  = (sw_q == SW_RUN) | (sw_q == SW_TERM);
  wire sw_is_on   = (i_mode_sw == SW_RUN) | (i_mode_sw == SW_TERM);
  // RULE7 selector restart edge
  wire restart    = sw_was_on & (i_mode_sw == SW_STOP);
  wire diag_done  = (mode_q == MODE_DIAG) & (diag_cnt_q == DIAG_LAST);
  wire in_run     = (mode_q == MODE_RUN);

  // RULE20 user or software stop request
  wire stop_req   = i_user_stop | (wr_ctl & i_pwdata[CTL_STOP]);

  // error classification
  // RULE18 pointer beyond range
  wire ptr_err    = in_run & i_ptr_valid & (i_ptr_addr > PTR_LIMIT);
  // RULE11 run-time errors seen in run
  wire rt_err     = in_run & i_rt_err;
  // RULE16 violation aborts download
  wire dl_abort   = dl_active_q & i_dl_viol;
  // RULE1 fatal class wins over every other mode change; non-fatal flags and codes still log in the same cycle
  wire fatal_evt  = i_fatal_err & (mode_q != MODE_FATAL);
  wire diag_fatal = diag_done & i_diag_fail;

  // i/o configuration compare
  wire refresh_tick = (refresh_cnt_q == REFRESH_LEN - 1);
  wire cfg_mismatch = (i_io_cfg != cfg_store_q);

  // special flag set and clear terms
  logic [SF_WIDTH-1:0] sf_set;
  logic [SF_WIDTH-1:0] sf_clr;
  always_comb begin
    sf_set             = '0;
    sf_clr             = wr_sflag ? i_pwdata[SF_WIDTH-1:0] : '0;
    sf_set[SF_RUNTIME] = rt_err;
    sf_set[SF_COMPILE] = dl_abort;
    sf_set[SF_RTPROG]  = ptr_err;
    // RULE14 mismatch raises changed flag
    sf_set[SF_CFGCHG]  = in_run & refresh_tick & cfg_mismatch;
    // RULE15 clear only once i/o matches again
    sf_clr[SF_CFGCHG]  = in_run & refresh_tick & ~cfg_mismatch;
  end

  // mode sequencing
  always_comb begin
    mode_d = mode_q;
    unique case (mode_q)
      MODE_DIAG: begin
        // RULE9 diagnostics outcome
        if (diag_fatal || fatal_evt) begin
          mode_d = MODE_FATAL;
        end else if (diag_done) begin
          mode_d = (sw_is_on && !stop_hold_q) ? MODE_RUN : MODE_STOP;
        end
      end
      MODE_RUN: begin
        // RULE19 non-fatal errors keep mode
        if (fatal_evt) begin
          mode_d = MODE_FATAL;
        end else if (stop_req || !sw_is_on) begin
          mode_d = MODE_STOP;
        end
      end
      MODE_STOP: begin
        if (fatal_evt) begin
          mode_d = MODE_FATAL;
        end else if (sw_is_on && !stop_hold_q && !ctl_stop_q) begin
          mode_d = MODE_RUN;
        end
      end
      MODE_FATAL: begin
        // RULE6 hold until restart
        // RULE8 restart reruns diagnostics
        if (restart) begin
          mode_d = MODE_DIAG;
        end
      end
    endcase
  end

  // mode register and selector history
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mode_q <= MODE_DIAG;
      sw_q   <= SW_STOP;
    end else begin
      mode_q <= mode_d;
      sw_q   <= i_mode_sw;
    end
  end

  // power-up diagnostic timer
  always_ff @(posedge i_clk) begin
    if (i_rst || mode_q != MODE_DIAG) begin
      diag_cnt_q <= '0;
    end else if (!diag_done) begin
      diag_cnt_q <= diag_cnt_q + 16'h0001;
    end
  end

  // stop latch until selector passes through stop
  always_ff @(posedge i_clk) begin
    if (i_rst || i_mode_sw == SW_STOP) begin
      stop_hold_q <= 1'b0;
    end else if (in_run && i_user_stop) begin
      stop_hold_q <= 1'b1;
    end
  end

  // software control register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctl_stop_q <= 1'b0;
    end else if (wr_ctl) begin
      ctl_stop_q <= i_pwdata[CTL_STOP];
    end
  end

  // RULE21 last fatal code, cleared on restart
  always_ff @(posedge i_clk) begin
    if (i_rst || (mode_q == MODE_FATAL && restart)) begin
      fatal_code_q <= CODE_RST;
    end else if (fatal_evt) begin
      // RULE2 fatal code kept for readback
      fatal_code_q <= i_fatal_code;
    end else if (diag_fatal) begin
      fatal_code_q <= i_fatal_code;
    end
  end

  // RULE2 last non-fatal code and category
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      nf_code_q <= CODE_RST;
      nf_cat_q  <= CAT_NONE;
    end else if (dl_abort) begin
      nf_code_q <= i_dl_viol_code;
      nf_cat_q  <= CAT_COMPILE;
    end else if (ptr_err) begin
      nf_code_q <= CODE_PTR;
      nf_cat_q  <= CAT_RTPROG;
    end else if (rt_err) begin
      nf_code_q <= i_rt_code;
      nf_cat_q  <= CAT_RUNTIME;
    end
  end

  // special flags, set wins over clear
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sf_q <= '0;
    end else begin
      sf_q <= (sf_q & ~sf_clr) | sf_set;
    end
  end

  // RULE12 capture configuration at startup
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cfg_store_q <= CFG_RST;
    end else if (diag_done && !i_diag_fail) begin
      cfg_store_q <= i_io_cfg;
    end
  end

  // RULE13 periodic status refresh
  always_ff @(posedge i_clk) begin
    if (i_rst || refresh_tick) begin
      refresh_cnt_q <= '0;
    end else begin
      refresh_cnt_q <= refresh_cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      io_stat_q <= CFG_RST;
    end else if ((diag_done && !i_diag_fail) || (in_run && refresh_tick)) begin
      io_stat_q <= i_io_cfg;
    end
  end

  // download tracking
  always_ff @(posedge i_clk) begin
    if (i_rst || dl_abort || i_dl_end) begin
      dl_active_q <= 1'b0;
    end else if (i_dl_start) begin
      dl_active_q <= 1'b1;
    end
  end

  // RULE17 commit only a clean download
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      commit_q <= 1'b0;
    end else begin
      commit_q <= dl_active_q & i_dl_end & ~i_dl_viol;
    end
  end

  // read mux, captured in setup phase
  logic [31:0] rdata_d;
  always_comb begin
    rdata_d = '0;
    if (hit_status) begin
      rdata_d[1:0] = mode_q;
      rdata_d[2]   = (mode_q == MODE_FATAL);
      rdata_d[3]   = sf_q[SF_CFGCHG];
      rdata_d[4]   = dl_active_q;
    end else if (hit_fatal) begin
      rdata_d[CODE_W-1:0] = fatal_code_q;
    end else if (hit_nfatal) begin
      rdata_d[CODE_W-1:0]      = nf_code_q;
      rdata_d[CODE_W+1:CODE_W] = nf_cat_q;
    end else if (hit_sflag) begin
      rdata_d[SF_WIDTH-1:0] = sf_q;
    end else if (hit_ctl) begin
      rdata_d[CTL_STOP] = ctl_stop_q;
    end else if (hit_iocfg) begin
      rdata_d[CFG_W-1:0]       = cfg_store_q;
      rdata_d[2*CFG_W-1:CFG_W] = io_stat_q;
    end
  end

  // RULE4 bus answers in every mode
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_q <= '0;
    end else if (apb_setup && !i_pwrite) begin
      rdata_q <= rdata_d;
    end
  end

  // apb answer
  assign o_pready  = apb_access;
  assign o_pslverr = apb_access & ~hit_any;
  assign o_prdata  = rdata_q;

  // RULE3 program halts outside run
  assign o_prog_run     = in_run;
  // RULE5 fatal lamps and outputs off
  assign o_fault_led    = (mode_q == MODE_FATAL);
  assign o_stop_led     = ~in_run;
  assign o_outputs_off  = ~in_run;
  // RULE10 non-fatal leaves updates on
  // RULE14 freeze module while changed
  assign o_io_update_en = in_run & ~sf_q[SF_CFGCHG];
  assign o_prog_commit  = commit_q;
  assign o_sf_flags     = sf_q;
  assign o_sf_io_status = io_stat_q;

endmodule

`default_nettype wire

// *** sim/fault_supervisor_props.sv ***
`timescale 1ns/100ps
`default_nettype none
module fault_supervisor_props
  import fault_supervisor_pkg::*;
(
  // clock, reset and bus
  input wire logic                                 i_clk,
  input wire logic                                 i_rst,
  input wire logic                                 i_psel,
  input wire logic                                 i_penable,
  input wire logic                                 o_pready,
  input wire logic                                 o_pslverr,
  // selector and error sources
  input wire logic [1:0]                           i_mode_sw,
  input wire logic                                 i_fatal_err,
  input wire logic                                 i_rt_err,
  input wire logic                                 i_ptr_valid,
  input wire logic [15:0]                          i_ptr_addr,
  // status
  input wire logic                                 o_prog_run,
  input wire logic                                 o_stop_led,
  input wire logic                                 o_fault_led,
  input wire logic                                 o_outputs_off,
  input wire logic                                 o_io_update_en,
  input wire logic [fault_supervisor_pkg::SF_WIDTH-1:0] o_sf_flags
);
  // one clock domain
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  fatal_entry_a: assert property (i_fatal_err && !o_fault_led |=> o_fault_led && !o_prog_run)
    else $error("fatal error did not halt");
  fatal_lamps_a: assert property (o_fault_led |-> o_stop_led && o_outputs_off)
    else $error("fatal lamps or outputs wrong");
  fatal_hold_a: assert property (
    o_fault_led && (i_mode_sw == SW_RUN || i_mode_sw == SW_TERM) |=> o_fault_led)
    else $error("fatal state left early");
  restart_clear_a: assert property (
    o_fault_led && i_mode_sw == SW_STOP && !i_fatal_err &&
    ($past(i_mode_sw) == SW_RUN || $past(i_mode_sw) == SW_TERM) |=> !o_fault_led)
    else $error("restart did not clear fatal");
  io_freeze_a: assert property (o_io_update_en |-> o_prog_run && !o_sf_flags[SF_CFGCHG])
    else $error("io updated while config changed");
  bus_ready_a: assert property (o_pready == (i_psel && i_penable))
    else $error("pready outside access phase");
  bus_err_a: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
  rt_flag_a: assert property (
    o_prog_run && i_rt_err && !i_fatal_err |=> o_sf_flags[SF_RUNTIME])
    else $error("runtime flag not set");
  ptr_flag_a: assert property (
    o_prog_run && i_ptr_valid && i_ptr_addr > PTR_LIMIT && !i_fatal_err
    |=> o_sf_flags[SF_RTPROG]) else $error("pointer flag not set");

  // main scenarios reached
  cover property (o_fault_led ##1 !o_fault_led);
  cover property ($rose(o_sf_flags[SF_CFGCHG]));
  cover property (o_pslverr);
endmodule
`default_nettype wire

// *** sim/station_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module station_model (
  // clock
  input  wire logic        i_clk,
  // apb master side
  output logic             o_psel,
  output logic             o_penable,
  output logic             o_pwrite,
  output logic [7:0]       o_paddr,
  output logic [31:0]      o_pwdata,
  input  wire logic [31:0] i_prdata,
  input  wire logic        i_pready,
  input  wire logic        i_pslverr
);
  // idle bus from time zero
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h00;
    o_pwdata = 32'h0;
  end

  // one transfer: setup, access until ready, then release
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge i_clk);
    o_psel <= 1'b1;
    o_pwrite <= wr;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_clk);
    o_penable <= 1'b1;
    @(posedge i_clk);
    while (i_pready !== 1'b1) @(posedge i_clk);
    q = i_prdata;
    e = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    o_paddr <= ~a;
    o_pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// *** sim/controller_fault_supervisor_test.sv ***
`timescale 1ns/100ps
`default_nettype none
module controller_fault_supervisor_test;
  import fault_supervisor_pkg::*;
  localparam int unsigned REF_LEN = 8;
  // design inputs and outputs
  logic        i_clk = 1'b0, i_rst = 1'b1, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
  logic [7:0]  i_paddr, i_fatal_code = 8'h0, i_rt_code = 8'h0, i_dl_viol_code = 8'h0;
  logic [7:0]  i_io_cfg = 8'ha5, o_sf_io_status;
  logic [31:0] i_pwdata, o_prdata, q;
  logic [1:0]  i_mode_sw = SW_RUN;
  logic        i_diag_fail = 0, i_fatal_err = 0, i_rt_err = 0, i_ptr_valid = 0, i_user_stop = 0;
  logic        i_dl_start = 0, i_dl_viol = 0, i_dl_end = 0, e;
  logic [15:0] i_ptr_addr = 16'h0;
  logic        o_prog_run, o_stop_led, o_fault_led, o_outputs_off, o_io_update_en, o_prog_commit;
  logic [3:0]  o_sf_flags;
  int          n_fail = 0, n_checks = 0;

  controller_fault_supervisor #(.REFRESH_LEN(REF_LEN)) controller_fault_supervisor_inst (
    .i_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
    .o_pslverr, .i_mode_sw, .i_diag_fail, .i_fatal_err, .i_fatal_code, .i_rt_err, .i_rt_code,
    .i_ptr_valid, .i_ptr_addr, .i_user_stop, .i_dl_start, .i_dl_viol, .i_dl_viol_code,
    .i_dl_end, .i_io_cfg, .o_prog_run, .o_stop_led, .o_fault_led, .o_outputs_off,
    .o_io_update_en, .o_prog_commit, .o_sf_flags, .o_sf_io_status);
  station_model station_model_inst (.i_clk, .o_psel(i_psel), .o_penable(i_penable),
    .o_pwrite(i_pwrite), .o_paddr(i_paddr), .o_pwdata(i_pwdata), .i_prdata(o_prdata),
    .i_pready(o_pready), .i_pslverr(o_pslverr));

  // 50 MHz clock
  always #10 i_clk = ~i_clk;

  task automatic chk(string n, logic [31:0] s, logic [31:0] x);
    n_checks++;
    if (s !== x) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic rd(logic [7:0] a);
    station_model_inst.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    station_model_inst.xfer(1'b1, a, d, q, e);
  endtask
  task automatic final_report;
    if (n_fail == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic t_boot;
    rd(ADDR_STATUS);
    chk("boot mode", q[1:0], MODE_DIAG);
    rd(ADDR_FATAL);
    chk("boot fatal", q, 0);
    station_model_inst.xfer(1'b0, 8'h18, 32'h0, q, e);
    chk("unmapped err", e, 1);
    chk("unmapped data", q, 0);
    tick(DIAG_CYCLES);
    chk("boot run", o_prog_run, 1);
    rd(ADDR_IOCFG);
    chk("stored cfg", q[7:0], 8'ha5);
  endtask
  task automatic t_nonfatal;
    @(posedge i_clk) {i_rt_err, i_rt_code} <= {1'b1, 8'h5a};
    @(posedge i_clk) i_rt_err <= 0;
    #1 chk("rt flag", o_sf_flags[SF_RUNTIME], 1);
    chk("rt keeps run", {o_prog_run, o_io_update_en}, 2'b11);
    rd(ADDR_NFATAL);
    chk("rt code", q[9:0], {CAT_RUNTIME, 8'h5a});
    @(posedge i_clk) {i_ptr_valid, i_ptr_addr} <= {1'b1, 16'h1000};
    @(posedge i_clk) i_ptr_valid <= 0;
    #1 chk("ptr flag", o_sf_flags[SF_RTPROG], 1);
    rd(ADDR_NFATAL);
    chk("ptr code", q[9:0], {CAT_RTPROG, CODE_PTR});
    wr(ADDR_SFLAG, 32'h5);
    rd(ADDR_SFLAG);
    chk("flags cleared", q[3:0], 0);
  endtask
  task automatic t_download;
    @(posedge i_clk) i_dl_start <= 1;
    @(posedge i_clk) {i_dl_start, i_dl_viol, i_dl_viol_code} <= {2'b01, 8'h33};
    @(posedge i_clk) {i_dl_viol, i_dl_end} <= 2'b01;
    @(posedge i_clk) i_dl_end <= 0;
    #1 chk("abort no commit", o_prog_commit, 0);
    chk("compile flag", o_sf_flags[SF_COMPILE], 1);
    rd(ADDR_NFATAL);
    chk("compile code", q[9:0], {CAT_COMPILE, 8'h33});
    @(posedge i_clk) i_dl_start <= 1;
    @(posedge i_clk) {i_dl_start, i_dl_end} <= 2'b01;
    @(posedge i_clk) i_dl_end <= 0;
    #1 chk("clean commit", o_prog_commit, 1);
    chk("dl keeps run", o_prog_run, 1);
  endtask
  task automatic t_config;
    @(posedge i_clk) i_io_cfg <= 8'h3c;
    tick(2 * REF_LEN + 2);
    chk("cfg changed", {o_sf_flags[SF_CFGCHG], o_io_update_en}, 2'b10);
    chk("cfg keeps run", o_prog_run, 1);
    chk("io status", o_sf_io_status, 8'h3c);
    rd(ADDR_IOCFG);
    chk("cfg kept", q[7:0], 8'ha5);
    chk("live status", q[15:8], 8'h3c);
    @(posedge i_clk) i_io_cfg <= 8'ha5;
    tick(2 * REF_LEN + 2);
    chk("cfg matched", {o_sf_flags[SF_CFGCHG], o_io_update_en}, 2'b01);
  endtask
  task automatic t_stop;
    @(posedge i_clk) i_user_stop <= 1;
    @(posedge i_clk) i_user_stop <= 0;
    tick(1);
    chk("user stop", {o_prog_run, o_stop_led, o_outputs_off}, 3'b011);
    @(posedge i_clk) i_mode_sw <= SW_STOP;
    tick(3);
    @(posedge i_clk) i_mode_sw <= SW_RUN;
    tick(3);
    chk("rerun", o_prog_run, 1);
    wr(ADDR_CONTROL, 32'h1);
    tick(2);
    chk("ctl stop", o_prog_run, 0);
    wr(ADDR_CONTROL, 32'h0);
    tick(2);
    chk("ctl run", o_prog_run, 1);
  endtask
  task automatic t_fatal;
    @(posedge i_clk) {i_fatal_err, i_fatal_code} <= {1'b1, 8'h77};
    @(posedge i_clk) i_fatal_err <= 0;
    #1 chk("fatal lamps", {o_fault_led, o_stop_led, o_outputs_off, o_prog_run}, 4'he);
    rd(ADDR_FATAL);
    chk("fatal code", q[7:0], 8'h77);
    rd(ADDR_STATUS);
    chk("fatal status", q[2:0], {1'b1, MODE_FATAL});
    tick(20);
    chk("fatal held", o_fault_led, 1);
    @(posedge i_clk) {i_mode_sw, i_diag_fail, i_fatal_code} <= {SW_STOP, 1'b1, 8'h66};
    tick(2);
    chk("restart", o_fault_led, 0);
    rd(ADDR_FATAL);
    chk("fatal cleared", q, 0);
    tick(DIAG_CYCLES);
    chk("diag refault", o_fault_led, 1);
    rd(ADDR_FATAL);
    chk("diag code", q[7:0], 8'h66);
    // restart this time from the terminal position
    @(posedge i_clk) i_mode_sw <= SW_TERM;
    @(posedge i_clk) {i_mode_sw, i_diag_fail} <= {SW_STOP, 1'b0};
    tick(DIAG_CYCLES + 4);
    rd(ADDR_STATUS);
    chk("diag pass", q[2:0], {1'b0, MODE_STOP});
    @(posedge i_clk) i_mode_sw <= SW_RUN;
    tick(3);
    chk("resumed", o_prog_run, 1);
    @(posedge i_clk) i_fatal_err <= 1;
    @(posedge i_clk) {i_fatal_err, i_rst} <= 2'b01;
    tick(2);
    @(posedge i_clk) i_rst <= 0;
    #1 chk("power restart", o_fault_led, 0);
    chk("reset flags", {o_sf_flags, o_prog_run}, 5'h00);
  endtask

  // main sequence
  initial begin
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    t_boot();
    t_nonfatal();
    t_download();
    t_config();
    t_stop();
    t_fatal();
    final_report();
  end
  // watchdog against a hang
  initial begin
    repeat (8000) @(posedge i_clk);
    n_fail++;
    final_report();
  end
endmodule

bind controller_fault_supervisor fault_supervisor_props fault_supervisor_props_inst (
  .i_clk, .i_rst, .i_psel, .i_penable, .o_pready, .o_pslverr, .i_mode_sw, .i_fatal_err,
  .i_rt_err, .i_ptr_valid, .i_ptr_addr, .o_prog_run, .o_stop_led, .o_fault_led,
  .o_outputs_off, .o_io_update_en, .o_sf_flags);
`default_nettype wire
